// ===== drp_pkg.sv
// Package: states, role modes and timing constants for the attach state machine
package drp_pkg;

   // =====================================================================
   // Port role configuration
   // =====================================================================
   typedef enum logic [1:0] {
      ROLE_SOURCE = 2'b00,
      ROLE_SINK   = 2'b01,
      ROLE_DUAL   = 2'b10
   } drp_role_t;

   // =====================================================================
   // Connection states
   // =====================================================================
   typedef enum logic [2:0] {
      ST_UNATTACHED_SOURCE  = 3'b000,
      ST_UNATTACHED_SINK    = 3'b001,
      ST_SOURCE_ATTACH_WAIT = 3'b010,
      ST_ATTACHED_SOURCE    = 3'b011,
      ST_ATTACHED_SINK      = 3'b100,
      ST_TRY_SOURCE         = 3'b101,
      ST_SINK_LOCK          = 3'b110
   } drp_state_t;

   // =====================================================================
   // Timing (clock 125 MHz)
   // =====================================================================
   localparam int CLK_PERIOD_PS      = 8000;
   localparam int HOLD_INTERVAL_US   = 100;
   localparam int LOCK_INTERVAL_US   = 100;
   localparam int TOGGLE_HALF_US     = 35;
   // Cycle counts rounded down (shortest times), with no lower bound applied
   localparam int HOLD_CYCLES   = (HOLD_INTERVAL_US * 1000000) / CLK_PERIOD_PS;
   localparam int LOCK_CYCLES   = (LOCK_INTERVAL_US * 1000000) / CLK_PERIOD_PS;
   localparam int TOGGLE_CYCLES = (TOGGLE_HALF_US * 1000000) / CLK_PERIOD_PS;
   localparam int TIMER_W       = 24;

   // Current advertisement levels
   localparam logic [1:0] ADV_DEFAULT = 2'h0;
   localparam logic [1:0] ADV_1A5     = 2'h1;
   localparam logic [1:0] ADV_3A0     = 2'h2;
   localparam logic [1:0] ADV_RESET   = 2'h0;

endpackage

// ===== drp_timer.sv
// Restartable down-counting interval timer with one-cycle expiry pulse
`timescale 1ns/1ps

module drp_timer #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             start_in,
   input  wire logic [WIDTH-1:0] load_in,
   output logic                  expire_out
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             run;
      logic             expire;
   } drp_tmr_t;

   drp_tmr_t tmr_q;
   drp_tmr_t tmr_d;

   // =====================================================================
   // Next state: start restarts the count from load
   // =====================================================================
   always_comb begin
      tmr_d        = tmr_q;
      tmr_d.expire = 1'b0;
      if (start_in) begin
         tmr_d.count = load_in;
         tmr_d.run   = 1'b1;
      end else if (tmr_q.run) begin
         if (tmr_q.count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            tmr_d.run    = 1'b0;
            tmr_d.expire = 1'b1;
         end else begin
            tmr_d.count = tmr_q.count - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // Register stage
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_d;
      end
   end

   assign expire_out = tmr_q.expire;

endmodule // drp_timer

// ===== drp_attach_fsm.sv
// Attach state machine for a reversible-connector source, sink or dual-role port
// Detect inputs come from the analogue front end, so each one crosses
// two flip-flops and a two-sample agreement filter before the machine
// acts on it; an attach or detach is thus seen about five cycles late.
// The filter trades that latency for immunity to single-cycle glitches
// on CC while the far side is still mating.
// Try source has no timeout of its own: a partner that never answers
// with a pull-down leaves the port there until the next reset.
// Role changes are taken as they come; while attached they only steer
// where a detach leads, never the attached state itself.
// Hold, lock and toggle figures are cycle counts of the one clock, so a
// faster or slower clock needs the parameters scaled to match.
`timescale 1ns/1ps

module drp_attach_fsm
   import drp_pkg::*;
#(
   parameter int HOLD_COUNT   = HOLD_CYCLES,
   parameter int LOCK_COUNT   = LOCK_CYCLES,
   parameter int TOGGLE_COUNT = TOGGLE_CYCLES
) (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic [1:0] role_in,
   input  wire logic       prefer_source_in,
   input  wire logic [1:0] advert_level_in,
   input  wire logic       cc_pulldown_in,
   input  wire logic       cc_pullup_in,
   input  wire logic [1:0] cc_sense_level_in,
   input  wire logic       vbus_present_in,
   output logic            pullup_en_out,
   output logic            pulldown_en_out,
   output logic            vbus_en_out,
   output logic            vconn_en_out,
   output logic [1:0]      advert_level_out,
   output logic [1:0]      sink_current_out,
   output logic            pd_allowed_out,
   output logic            attached_out,
   output logic [2:0]      state_out
);

   // =====================================================================
   // State of the module in one record
   // =====================================================================
   typedef struct packed {
      // Detect synchronisers: bit 0 first stage, bit 1 second stage
      logic [1:0] pd_sync1;    // First stages: read only by second stages
      logic [1:0] pd_sync2;
      logic [1:0] pu_sync1;
      logic [1:0] pu_sync2;
      logic [1:0] vb_sync1;
      logic [1:0] vb_sync2;
      logic [1:0] sense_s1;
      logic [1:0] sense_s2;
      // Connection state and the dual-role toggle timer
      drp_state_t state;
      logic       via_try;     // Attach wait reached from try source
      logic [TIMER_W-1:0] toggle_cnt;
      // Outputs, registered from the next state
      logic       pullup_en;
      logic       pulldown_en;
      logic       vbus_en;
      logic       vconn_en;
      logic [1:0] advert;
      logic [1:0] sink_cur;
      logic       pd_allowed;
      logic       attached;
   } drp_fsm_t;

   drp_fsm_t s_q;
   drp_fsm_t s_d;

   // Timer control and filtered detect levels
   logic                hold_start;
   logic                lock_start;
   logic                hold_expire;
   logic                lock_expire;
   logic                pd_det;
   logic                pu_det;
   logic                vb_det;
   drp_role_t           role;

   // =====================================================================
   // Interval timers
   // =====================================================================
   // Each restarts on every entry to its state
   // Expiry is a one-cycle pulse, seen only while still in that state
   drp_timer #(.WIDTH(TIMER_W)) u_hold (
      .clk_in     (clk_in),
      .reset_in   (reset_in),
      .start_in   (hold_start),
      .load_in    (TIMER_W'(HOLD_COUNT)),
      .expire_out (hold_expire)
   );

   drp_timer #(.WIDTH(TIMER_W)) u_lock (
      .clk_in     (clk_in),
      .reset_in   (reset_in),
      .start_in   (lock_start),
      .load_in    (TIMER_W'(LOCK_COUNT)),
      .expire_out (lock_expire)
   );

   // The role input comes from logic on this clock: no synchroniser
   // Synchronised detect levels (second stage only)
   assign pd_det = s_q.pd_sync2[1];
   assign pu_det = s_q.pu_sync2[1];
   assign vb_det = s_q.vb_sync2[1];
   assign role   = drp_role_t'(role_in);

   // =====================================================================
   // Next-state logic
   // =====================================================================
   always_comb begin
      s_d        = s_q;
      hold_start = 1'b0;
      lock_start = 1'b0;

      // Two-flop synchronisers; stage 2 then a one-cycle agreement filter
      s_d.pd_sync1 = {s_q.pd_sync1[0], cc_pulldown_in};
      s_d.pu_sync1 = {s_q.pu_sync1[0], cc_pullup_in};
      s_d.vb_sync1 = {s_q.vb_sync1[0], vbus_present_in};
      s_d.sense_s1 = cc_sense_level_in;
      s_d.sense_s2 = s_q.sense_s1;
      // Debounce: level changes only when two samples agree
      if (s_q.pd_sync1[1] == s_q.pd_sync2[0]) begin
         s_d.pd_sync2 = {s_q.pd_sync2[0], s_q.pd_sync1[1]};
      end else begin
         s_d.pd_sync2 = {s_q.pd_sync2[1], s_q.pd_sync1[1]};
      end
      if (s_q.pu_sync1[1] == s_q.pu_sync2[0]) begin
         s_d.pu_sync2 = {s_q.pu_sync2[0], s_q.pu_sync1[1]};
      end else begin
         s_d.pu_sync2 = {s_q.pu_sync2[1], s_q.pu_sync1[1]};
      end
      if (s_q.vb_sync1[1] == s_q.vb_sync2[0]) begin
         s_d.vb_sync2 = {s_q.vb_sync2[0], s_q.vb_sync1[1]};
      end else begin
         s_d.vb_sync2 = {s_q.vb_sync2[1], s_q.vb_sync1[1]};
      end

      // Detection wins over toggling in each unattached state, so a partner
      // seen in the last toggle cycle is still taken in that state.
      // Unused codes fall back to unattached source through default.
      case (s_q.state)
         ST_UNATTACHED_SOURCE: begin
            if (pd_det && role == ROLE_SOURCE) begin
               s_d.state = ST_ATTACHED_SOURCE;
            end else if (pd_det && role == ROLE_DUAL) begin
               s_d.state   = ST_SOURCE_ATTACH_WAIT;
               s_d.via_try = 1'b0;
               hold_start  = 1'b1;
            end else if (role == ROLE_SINK) begin
               s_d.state = ST_UNATTACHED_SINK;
            end else if (role == ROLE_DUAL &&
                         s_q.toggle_cnt >= TIMER_W'(TOGGLE_COUNT)) begin
               s_d.state      = ST_UNATTACHED_SINK;
               s_d.toggle_cnt = '0;
            end else if (role == ROLE_DUAL) begin
               s_d.toggle_cnt = s_q.toggle_cnt + TIMER_W'(1);
            end
            // Source-only with no pull-down just stays here
         end
         ST_UNATTACHED_SINK: begin
            if (vb_det && role == ROLE_DUAL && prefer_source_in) begin
               s_d.state = ST_TRY_SOURCE;
            end else if (vb_det && role != ROLE_SOURCE) begin
               s_d.state = ST_ATTACHED_SINK;
            end else if (role == ROLE_SOURCE) begin
               s_d.state = ST_UNATTACHED_SOURCE;
            end else if (role == ROLE_DUAL &&
                         s_q.toggle_cnt >= TIMER_W'(TOGGLE_COUNT)) begin
               s_d.state      = ST_UNATTACHED_SOURCE;
               s_d.toggle_cnt = '0;
            end else if (role == ROLE_DUAL) begin
               s_d.toggle_cnt = s_q.toggle_cnt + TIMER_W'(1);
            end
            // Sink-only without VBUS stays here
         end
         ST_TRY_SOURCE: begin
            // Pull-up shown, wait for partner's pull-down
            if (pd_det) begin
               s_d.state   = ST_SOURCE_ATTACH_WAIT;
               s_d.via_try = 1'b1;
               hold_start  = 1'b1;
            end
         end
         ST_SOURCE_ATTACH_WAIT: begin
            // A detach during the hold is left to attached source to notice
            if (hold_expire) begin
               s_d.state = ST_ATTACHED_SOURCE;
            end
         end
         ST_ATTACHED_SOURCE: begin
            if (!pd_det && role == ROLE_SOURCE) begin
               s_d.state = ST_UNATTACHED_SOURCE;
            end else if (!pd_det) begin
               s_d.state  = ST_SINK_LOCK;
               lock_start = 1'b1;
            end
         end
         ST_SINK_LOCK: begin
            // VBUS is checked first: a source that appears just as the lock
            // interval runs out is still taken as an attach
            if (vb_det) begin
               s_d.state = ST_ATTACHED_SINK;
            end else if (lock_expire) begin
               s_d.state      = ST_UNATTACHED_SOURCE;
               s_d.toggle_cnt = '0;
            end
         end
         ST_ATTACHED_SINK: begin
            // Only VBUS ends the attachment; CC merely steers the current
            if (!vb_det) begin
               s_d.state      = ST_UNATTACHED_SINK;
               s_d.toggle_cnt = '0;
            end
         end
         default: begin
            s_d.state = ST_UNATTACHED_SOURCE;
         end
      endcase

      // Outputs follow the next state so they change with the entry
      // Deriving them from s_d keeps terminations and supplies in step with
      // the state code; a late pull-up would show the partner a glitch.
      s_d.pullup_en   = (s_d.state == ST_UNATTACHED_SOURCE) ||
                        (s_d.state == ST_TRY_SOURCE) ||
                        (s_d.state == ST_SOURCE_ATTACH_WAIT) ||
                        (s_d.state == ST_ATTACHED_SOURCE);
      s_d.pulldown_en = (s_d.state == ST_UNATTACHED_SINK) ||
                        (s_d.state == ST_SINK_LOCK) ||
                        (s_d.state == ST_ATTACHED_SINK);
      s_d.vbus_en     = (s_d.state == ST_SOURCE_ATTACH_WAIT) ||
                        (s_d.state == ST_ATTACHED_SOURCE);
      // VCONN waits for attached source when the wait came via try
      s_d.vconn_en    = (s_d.state == ST_ATTACHED_SOURCE) ||
                        (s_d.state == ST_SOURCE_ATTACH_WAIT && !s_d.via_try);
      // Advertisement only meaningful while sourcing
      s_d.advert      = (s_d.state == ST_ATTACHED_SOURCE) ? advert_level_in : ADV_DEFAULT;
      // Sense level tracked every cycle while attached as sink
      s_d.sink_cur    = (s_d.state == ST_ATTACHED_SINK) ? s_q.sense_s2 : ADV_DEFAULT;
      s_d.attached    = (s_d.state == ST_ATTACHED_SOURCE) ||
                        (s_d.state == ST_ATTACHED_SINK);
      s_d.pd_allowed  = s_d.attached;
      // Pull-up detect is not needed beyond sink states; kept for visibility
      if (pu_det && s_d.state == ST_ATTACHED_SINK) begin
         s_d.attached = 1'b1;
      end
   end

   // =====================================================================
   // Register stage
   // =====================================================================
   // Reset clears every output, so all terminations are off until the
   // first edge after release; the port then opens as unattached source, or as unattached sink if the role is sink.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_q       <= '0;
         s_q.state <= ST_UNATTACHED_SOURCE;
         s_q.advert <= ADV_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Ports straight from the register record
   assign pullup_en_out    = s_q.pullup_en;
   assign pulldown_en_out  = s_q.pulldown_en;
   assign vbus_en_out      = s_q.vbus_en;
   assign vconn_en_out     = s_q.vconn_en;
   assign advert_level_out = s_q.advert;
   assign sink_current_out = s_q.sink_cur;
   assign pd_allowed_out   = s_q.pd_allowed;
   assign attached_out     = s_q.attached;
   assign state_out        = s_q.state;

endmodule // drp_attach_fsm

// ===== drp_attach_assertions.sv
// Checker for the attach state machine, bound to its ports
`timescale 1ns/1ps

module drp_attach_assertions #(
   parameter int HOLD_COUNT   = 16,
   parameter int LOCK_COUNT   = 16,
   parameter int TOGGLE_COUNT = 16
) (
   input wire logic       clk_in,
   input wire logic       reset_in,
   input wire logic [1:0] role_in,
   input wire logic       prefer_source_in,
   input wire logic [1:0] advert_level_in,
   input wire logic       cc_pulldown_in,
   input wire logic       cc_pullup_in,
   input wire logic [1:0] cc_sense_level_in,
   input wire logic       vbus_present_in,
   input wire logic       pullup_en_out,
   input wire logic       pulldown_en_out,
   input wire logic       vbus_en_out,
   input wire logic       vconn_en_out,
   input wire logic [1:0] advert_level_out,
   input wire logic [1:0] sink_current_out,
   input wire logic       pd_allowed_out,
   input wire logic       attached_out,
   input wire logic [2:0] state_out
);
   // ==================================================================
   // Helper: previous state and cycles spent in it
   // ==================================================================
   logic [2:0]  prev_q;
   logic [23:0] stay_q;
   logic        hold_ok;
   logic        lock_ok;

   // Window of two cycles either side tolerates the sync offset
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         prev_q <= 3'h0;
         stay_q <= 24'h0;
      end else begin
         prev_q <= state_out;
         stay_q <= (state_out == prev_q) ? stay_q + 24'h1 : 24'h0;
      end
   end
   assign hold_ok = (stay_q + 2 >= HOLD_COUNT) && (stay_q <= HOLD_COUNT + 2);
   assign lock_ok = (stay_q + 2 >= LOCK_COUNT) && (stay_q <= LOCK_COUNT + 2);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   // ==================================================================
   // Properties
   // ==================================================================
   property p_toggle;
      (role_in == 2'h2 && state_out <= 3'h1 && state_out == prev_q) |->
         stay_q <= TOGGLE_COUNT + 2;
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle stuck");
   property p_entry;
      (state_out == 3'h2 && prev_q != 3'h2) |-> (prev_q == 3'h0 || prev_q == 3'h5);
   endproperty
   a_entry: assert property (p_entry) else $error("bad wait entry");
   property p_wait_pwr;
      (state_out == 3'h2 && prev_q == 3'h0) |-> vbus_en_out && vconn_en_out;
   endproperty
   a_wait_pwr: assert property (p_wait_pwr) else $error("wait power off");
   property p_hold;
      (prev_q == 3'h2 && state_out == 3'h3) |-> hold_ok;
   endproperty
   a_hold: assert property (p_hold) else $error("hold length");
   property p_try;
      state_out == 3'h5 |-> pullup_en_out && !pulldown_en_out;
   endproperty
   a_try: assert property (p_try) else $error("try terms");
   property p_defer;
      (state_out == 3'h2 && !vconn_en_out) |=> (state_out != 3'h2 || !vconn_en_out);
   endproperty
   a_defer: assert property (p_defer) else $error("vconn early");
   property p_detach;
      (prev_q == 3'h3 && state_out != 3'h3 && role_in == 2'h2) |-> state_out == 3'h6;
   endproperty
   a_detach: assert property (p_detach) else $error("detach target");
   property p_lock_terms;
      state_out == 3'h6 |-> pulldown_en_out && !vbus_en_out && !vconn_en_out;
   endproperty
   a_lock_terms: assert property (p_lock_terms) else $error("lock terms");
   property p_lock;
      (prev_q == 3'h6 && state_out == 3'h0) |-> lock_ok;
   endproperty
   a_lock: assert property (p_lock) else $error("lock length");
   property p_pd;
      pd_allowed_out == (state_out == 3'h3 || state_out == 3'h4);
   endproperty
   a_pd: assert property (p_pd) else $error("messaging gate");

   // Main paths reached
   c_try: cover property (prev_q == 3'h5 && state_out == 3'h2);
   c_lock_sink: cover property (prev_q == 3'h6 && state_out == 3'h4);
   c_lock_src: cover property (prev_q == 3'h6 && state_out == 3'h0);
endmodule // drp_attach_assertions

// ===== drp_far_port.sv
// Behavioural far-side port: sink, legacy host or yielding dual-role port
`timescale 1ns/1ps

module drp_far_port (
   input  wire logic       pullup_en_in,
   input  wire logic       pulldown_en_in,
   input  wire logic [1:0] mode_in,
   input  wire logic [1:0] level_in,
   output logic            cc_pulldown_out,
   output logic            cc_pullup_out,
   output logic [1:0]      cc_sense_out,
   output logic            vbus_out
);
   // ==================================================================
   // Modes: 0 open, 1 sink adapter, 2 legacy host, 3 yielding port
   // ==================================================================
   logic src;

   // Mode 3 drops VBUS and pulls down once our port pulls up
   always_comb begin
      src = (mode_in == 2'h2) || (mode_in == 2'h3 && !pullup_en_in);
      cc_pulldown_out = pullup_en_in && (mode_in == 2'h1 || (mode_in == 2'h3 && !src));
      cc_pullup_out = pulldown_en_in && src;
      vbus_out = src;
      cc_sense_out = 2'h0; // Legacy host only ever shows the default level
      if (pulldown_en_in && mode_in == 2'h3) begin
         cc_sense_out = level_in; // Yielding port advertises as told
      end
   end
endmodule // drp_far_port

// ===== testbench.sv
// Self-checking bench for the attach state machine
`timescale 1ns/1ps

module testbench;
   localparam int HOLD = 12;
   localparam int LOCK = 14;
   localparam int TOG  = 10;
   logic       clk_in = 1'b0;
   logic       reset_in = 1'b1;
   logic [1:0] role = 2'h2;
   logic       prefer = 1'b0;
   logic [1:0] adv = 2'h2;
   logic [1:0] mode = 2'h0;
   logic [1:0] level = 2'h1;
   logic       pd, pu, vbus, pu_en, pd_en, vbus_en, vconn_en, pd_ok, att;
   logic [1:0] sense, adv_out, cur;
   logic [2:0] st;
   int         err_count = 0;
   int         checks = 0;
   int         cyc = 0;

   drp_attach_fsm #(.HOLD_COUNT(HOLD), .LOCK_COUNT(LOCK), .TOGGLE_COUNT(TOG)) i_drp_attach_fsm (
      .clk_in(clk_in), .reset_in(reset_in), .role_in(role), .prefer_source_in(prefer),
      .advert_level_in(adv), .cc_pulldown_in(pd), .cc_pullup_in(pu),
      .cc_sense_level_in(sense), .vbus_present_in(vbus), .pullup_en_out(pu_en),
      .pulldown_en_out(pd_en), .vbus_en_out(vbus_en), .vconn_en_out(vconn_en),
      .advert_level_out(adv_out), .sink_current_out(cur), .pd_allowed_out(pd_ok),
      .attached_out(att), .state_out(st));
   drp_far_port i_drp_far_port (
      .pullup_en_in(pu_en), .pulldown_en_in(pd_en), .mode_in(mode), .level_in(level),
      .cc_pulldown_out(pd), .cc_pullup_out(pu), .cc_sense_out(sense), .vbus_out(vbus));

   // ==================================================================
   // Clock, hang guard and checking tasks
   // ==================================================================
   initial begin
      forever #4 clk_in = ~clk_in;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         give_verdict();
      end
   end
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      checks = checks + 1;
      if (got != exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for a state at falling edges
   task automatic wait_st(input logic [2:0] s, input int lim);
      int n;
      n = 0;
      while (st !== s && n < lim) begin
         @(negedge clk_in);
         n++;
      end
      chk(st, s);
   endtask
   // Counts cycles spent in a state, entered at the current edge
   task automatic stay(input logic [2:0] s, input int exp);
      int n;
      n = 0;
      while (st === s && n < 1000) begin
         @(negedge clk_in);
         n++;
      end
      chk_n(n, exp);
   endtask
   task automatic restart(input logic [1:0] r, input logic p);
      @(negedge clk_in);
      reset_in = 1'b1;
      role = r;
      prefer = p;
      mode = 2'h0;
      repeat (4) @(negedge clk_in);
      reset_in = 1'b0;
   endtask

   // ==================================================================
   // Scenarios
   // ==================================================================
   task automatic t_toggle();
      restart(2'h2, 1'b0);
      wait_st(3'h1, TOG + 6);
      stay(3'h1, TOG + 1);
      chk(st, 3'h0);
   endtask
   task automatic t_src_attach();
      restart(2'h2, 1'b0);
      mode = 2'h1;
      wait_st(3'h2, 3 * TOG);
      chk({vbus_en, vconn_en, pd_en}, 3'b110);
      chk({att, pd_ok, pu_en}, 3'b001);
      stay(3'h2, HOLD + 1);
      chk(st, 3'h3);
      @(negedge clk_in);
      chk({pd_ok, adv_out}, {1'b1, adv});
      mode = 2'h0;
      wait_st(3'h6, 10);
      chk({vbus_en, vconn_en, pd_en}, 3'b001);
      stay(3'h6, LOCK + 1);
      chk(st, 3'h0);
   endtask
   task automatic t_try();
      restart(2'h2, 1'b1);
      wait_st(3'h1, TOG + 6);
      mode = 2'h3;
      wait_st(3'h5, 10);
      chk({pu_en, pd_en, vbus_en}, 3'b100);
      wait_st(3'h2, 12);
      chk({vbus_en, vconn_en, pu_en}, 3'b101);
      stay(3'h2, HOLD + 1);
      chk({vbus_en, vconn_en, pd_ok}, 3'b111);
      mode = 2'h0;
      wait_st(3'h6, 10);
      mode = 2'h2;
      wait_st(3'h4, 10);
      repeat (4) @(negedge clk_in);
      chk({pd_ok, cur}, 3'b100);
      mode = 2'h0;
      wait_st(3'h1, 10);
      wait_st(3'h0, TOG + 4);
   endtask
   task automatic t_sink();
      restart(2'h2, 1'b0);
      wait_st(3'h1, TOG + 6);
      mode = 2'h3;
      wait_st(3'h4, 10);
      repeat (5) @(negedge clk_in);
      chk({pd_ok, cur}, {1'b1, level});
      chk({att, pu_en, pd_en}, 3'b101);
      level = 2'h2;
      repeat (5) @(negedge clk_in);
      chk({pd_ok, cur}, {1'b1, level});
      mode = 2'h0;
      wait_st(3'h1, 10);
   endtask
   task automatic t_single();
      restart(2'h0, 1'b0);
      repeat (30) @(negedge clk_in);
      chk(st, 3'h0);
      mode = 2'h1;
      wait_st(3'h3, 8);
      chk({vbus_en, vconn_en, pd_ok}, 3'b111);
      chk({att, pu_en, pd_en}, 3'b110);
      mode = 2'h0;
      wait_st(3'h0, 8);
      restart(2'h1, 1'b0);
      repeat (30) @(negedge clk_in);
      chk(st, 3'h1);
      mode = 2'h2;
      wait_st(3'h4, 8);
      mode = 2'h0;
      wait_st(3'h1, 8);
   endtask

   task automatic give_verdict();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      t_toggle();
      t_src_attach();
      t_try();
      t_sink();
      t_single();
      give_verdict();
   end
endmodule // testbench

bind drp_attach_fsm drp_attach_assertions #(.HOLD_COUNT(HOLD_COUNT), .LOCK_COUNT(LOCK_COUNT),
   .TOGGLE_COUNT(TOGGLE_COUNT)) i_drp_attach_assertions (
   .clk_in(clk_in), .reset_in(reset_in), .role_in(role_in), .prefer_source_in(prefer_source_in),
   .advert_level_in(advert_level_in), .cc_pulldown_in(cc_pulldown_in),
   .cc_pullup_in(cc_pullup_in), .cc_sense_level_in(cc_sense_level_in),
   .vbus_present_in(vbus_present_in), .pullup_en_out(pullup_en_out),
   .pulldown_en_out(pulldown_en_out), .vbus_en_out(vbus_en_out), .vconn_en_out(vconn_en_out),
   .advert_level_out(advert_level_out), .sink_current_out(sink_current_out),
   .pd_allowed_out(pd_allowed_out), .attached_out(attached_out), .state_out(state_out));
